// ### hdl/breaker_flags_pkg.sv
// breaker_flags_pkg: constants, register map and types for the breaker status flags
// assumes a 10 MHz core clock and a 32-bit plain register port
`default_nettype none
package breaker_flags_pkg;

    // clock and timing
    localparam int CLK_FREQ_HZ     = 10_000_000;
    localparam int ACK_PULSE_MS    = 40;
    localparam int ACK_PULSE_CYC   = (CLK_FREQ_HZ / 1000) * ACK_PULSE_MS;
    localparam int SETTLE_TIME_MS  = 20;
    localparam int SETTLE_CYC      = (CLK_FREQ_HZ / 1000) * SETTLE_TIME_MS;

    typedef logic [23:0] tick_t;

    // register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] REMOTE_ADDR = 8'h04;
    localparam logic [7:0] CMD_ADDR    = 8'h08;
    localparam logic [7:0] STATUS_ADDR = 8'h0C;

    // control register fields
    localparam int CTRL_OP_LSB     = 0;
    localparam int CTRL_LAMP_BIT   = 2;
    localparam int CTRL_ALT1_BIT   = 3;
    localparam int CTRL_ALT2_BIT   = 4;
    localparam int CTRL_RSEL_BIT   = 5;
    localparam int CTRL_APP_LSB    = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] REMOTE_RESET = 8'h00;

    // command register bits (write one to act, reads zero)
    localparam int CMD_ACK      = 0;
    localparam int CMD_SYNC_A   = 1;
    localparam int CMD_OPEN_A   = 2;
    localparam int CMD_CLOSE_A  = 3;
    localparam int CMD_UNLOAD_A = 4;
    localparam int CMD_SYNC_B   = 5;
    localparam int CMD_OPEN_B   = 6;
    localparam int CMD_CLOSE_B  = 7;
    localparam int CMD_UNLOAD_B = 8;
    localparam int CMD_SETTLE   = 9;
    localparam int CMD_W        = 10;

    // status flag positions
    localparam int FLG_AUTO      = 0;
    localparam int FLG_MANUAL    = 1;
    localparam int FLG_LAMP      = 2;
    localparam int FLG_ACK       = 3;
    localparam int FLG_B_CLOSED  = 4;
    localparam int FLG_A_CLOSED  = 5;
    localparam int FLG_SETTLE    = 6;
    localparam int FLG_B_SYNC    = 7;
    localparam int FLG_B_OPEN    = 8;
    localparam int FLG_B_CLOSE   = 9;
    localparam int FLG_A_SYNC    = 10;
    localparam int FLG_A_OPEN    = 11;
    localparam int FLG_A_CLOSE   = 12;
    localparam int FLG_B_UNLOAD  = 13;
    localparam int FLG_A_UNLOAD  = 14;
    localparam int FLG_ALT1      = 15;
    localparam int FLG_ALT2      = 16;
    localparam int FLG_REMOTE    = 17;
    localparam int REMOTE_W      = 8;
    localparam int FLAG_W        = 25;

    typedef enum logic [1:0] {OP_STOP, OP_AUTO, OP_MANUAL, OP_SPARE} op_mode_e;
    typedef enum logic [1:0] {APP_UNIT, APP_UNIT_SINGLE, APP_COMBINED, APP_RESERVED} app_mode_e;

    typedef struct packed {
        logic sync;
        logic opening;
        logic closing;
        logic unload;
    } brk_seq_s;

    localparam brk_seq_s BRK_IDLE = '{sync: 1'b0, opening: 1'b0, closing: 1'b0, unload: 1'b0};

endpackage
`default_nettype wire

// ### hdl/ack_if.sv
// ack_if: acknowledge request and pulse between the flag block and its pulse stretcher
// assumes both ends run on the same clock
`default_nettype none
interface ack_if;
    logic req;
    logic pulse;
    modport src (output req, input pulse);
    modport gen (input req, output pulse);
endinterface
`default_nettype wire

// ### hdl/ack_pulse.sv
// ack_pulse: turns a one-cycle acknowledge request into a fixed-length pulse
// assumes req is a single-cycle strobe synchronous to core_clk
`default_nettype none
module ack_pulse
    import breaker_flags_pkg::*;
#(
    parameter tick_t PULSE_CYCLES = tick_t'(ACK_PULSE_CYC)
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // request and pulse
    ack_if.gen        ack
);

    tick_t cnt_q;
    tick_t cnt_d;
    logic  pulse_q;
    logic  pulse_d;

    // a new request restarts the full pulse length
    always_comb begin
        cnt_d   = cnt_q;
        if (ack.req) begin
            cnt_d = PULSE_CYCLES;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - tick_t'(1);
        end
        pulse_d = (cnt_d != '0);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_q   <= '0;
            pulse_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            pulse_q <= pulse_d;
        end
    end

    assign ack.pulse = pulse_q;

endmodule // ack_pulse
`default_nettype wire

// ### hdl/breaker_status_flags.sv
// breaker_status_flags: application status flags of a two-breaker control unit
// assumes reply inputs, button and register strobes are synchronous to core_clk
`default_nettype none
module breaker_status_flags
    import breaker_flags_pkg::*;
#(
    parameter tick_t ACK_CYCLES    = tick_t'(ACK_PULSE_CYC),
    parameter tick_t SETTLE_CYCLES = tick_t'(SETTLE_CYC)
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output var  logic [DATA_W-1:0] reg_rdata,
    // breaker reply inputs, high when energized
    input  wire logic              reply_input_a,
    input  wire logic              reply_input_b,
    // acknowledge sources
    input  wire logic              ack_button,
    input  wire logic              ack_ext,
    // relay outputs
    output var  logic              relay_close_b,
    output var  logic              relay_close_a5,
    output var  logic              relay_close_a6,
    // status flags to the user logic
    output var  logic [FLAG_W-1:0] status_flags
);

    // next state of one breaker's sequence flags; set by a command wins over any clear except an open command clearing closing
    function automatic brk_seq_s brk_next(
        input brk_seq_s cur,
        input logic     c_sync,
        input logic     c_open,
        input logic     c_close,
        input logic     c_unload,
        input logic     closed
    );
        brk_seq_s nxt;
        nxt = cur;
        if (c_sync) begin
            nxt.sync = 1'b1;
        end else if (closed) begin
            nxt.sync = 1'b0;
        end
        if (c_open) begin
            nxt.opening = 1'b1;
        end else if (!closed) begin
            nxt.opening = 1'b0;
        end
        // an open command overrides a close command for safety
        if (c_open) begin
            nxt.closing = 1'b0;
        end else if (c_close) begin
            nxt.closing = 1'b1;
        end else if (closed) begin
            nxt.closing = 1'b0;
        end
        if (c_unload) begin
            nxt.unload = 1'b1;
        end else if (c_open) begin
            nxt.unload = 1'b0;
        end
        return nxt;
    endfunction

    // one register strobe hitting one address
    function automatic logic reg_hit(
        input logic              strobe,
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] target
    );
        return strobe && (addr == target);
    endfunction

    // counts a timer down to zero and keeps it there
    function automatic tick_t count_down(input tick_t v);
        return (v == '0) ? v : v - tick_t'(1);
    endfunction

    // stretches every acknowledge request into the flag pulse
    ack_if ack ();

    ack_pulse #(
        .PULSE_CYCLES (ACK_CYCLES)
    ) u_ack_pulse (
        .core_clk (core_clk),
        .rst      (rst),
        .ack      (ack.gen)
    );

    // register state
    logic [7:0]        ctrl_q;
    logic [7:0]        ctrl_d;
    logic [7:0]        remote_q;
    logic [7:0]        remote_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [CMD_W-1:0]  cmd;

    // op mode 3 counts as neither automatic nor manual
    op_mode_e  op_mode;
    app_mode_e app_mode;

    assign op_mode  = op_mode_e'(ctrl_q[CTRL_OP_LSB +: 2]);
    assign app_mode = app_mode_e'(ctrl_q[CTRL_APP_LSB +: 2]);
    // command bits live only in their write cycle; nothing of them is stored
    assign cmd      = reg_hit(reg_wr, reg_addr, CMD_ADDR) ? reg_wdata[CMD_W-1:0] : '0;

    always_comb begin
        ctrl_d   = ctrl_q;
        remote_d = remote_q;
        rdata_d  = '0;
        if (reg_wr) begin
            case (reg_addr)
                CTRL_ADDR:   ctrl_d   = reg_wdata[7:0];
                REMOTE_ADDR: remote_d = reg_wdata[7:0];
                default:     ;
            endcase
        end
        // read data stand for one cycle only, zero otherwise
        if (reg_rd) begin
            case (reg_addr)
                CTRL_ADDR:   rdata_d = {24'h00_0000, ctrl_q};
                REMOTE_ADDR: rdata_d = {24'h00_0000, remote_q};
                STATUS_ADDR: rdata_d = {{(DATA_W-FLAG_W){1'b0}}, status_flags};
                default:     rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q   <= CTRL_RESET;
            remote_q <= REMOTE_RESET;
            rdata_q  <= '0;
        end else begin
            ctrl_q   <= ctrl_d;
            remote_q <= remote_d;
            rdata_q  <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // acknowledge sources: button edge, external strobe, software command
    logic btn_q;
    logic btn_d;

    always_comb begin
        // only the press edge counts, so a held button gives one pulse
        btn_d   = ack_button;
        ack.req = (ack_button && !btn_q) || ack_ext || cmd[CMD_ACK];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            btn_q <= 1'b0;
        end else begin
            btn_q <= btn_d;
        end
    end

    // mains settling timer, only meaningful in the two single-unit modes
    tick_t settle_q;
    tick_t settle_d;
    logic  single_mode;

    // leaving the single-unit modes stops the timer at once
    assign single_mode = (app_mode == APP_UNIT) || (app_mode == APP_UNIT_SINGLE);

    always_comb begin
        settle_d = settle_q;
        if (!single_mode) begin
            settle_d = '0;
        end else if (cmd[CMD_SETTLE]) begin
            settle_d = SETTLE_CYCLES;
        end else begin
            settle_d = count_down(settle_q);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            settle_q <= '0;
        end else begin
            settle_q <= settle_d;
        end
    end

    // breaker sequences
    brk_seq_s seq_a_q;
    brk_seq_s seq_a_d;
    brk_seq_s seq_b_q;
    brk_seq_s seq_b_d;
    logic     closed_a;
    logic     closed_b;

    // a reply contact is energized while its breaker is open
    assign closed_a = !reply_input_a;
    assign closed_b = !reply_input_b;

    always_comb begin
        seq_a_d = brk_next(seq_a_q, cmd[CMD_SYNC_A], cmd[CMD_OPEN_A], cmd[CMD_CLOSE_A],
                           cmd[CMD_UNLOAD_A], closed_a);
        seq_b_d = brk_next(seq_b_q, cmd[CMD_SYNC_B], cmd[CMD_OPEN_B], cmd[CMD_CLOSE_B],
                           cmd[CMD_UNLOAD_B], closed_b);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seq_a_q <= BRK_IDLE;
            seq_b_q <= BRK_IDLE;
        end else begin
            seq_a_q <= seq_a_d;
            seq_b_q <= seq_b_d;
        end
    end

    // flags and relays, rebuilt every cycle from the next state so they line up with it
    logic [FLAG_W-1:0] flags_q;
    logic [FLAG_W-1:0] flags_d;
    logic              rly_b_q;
    logic              rly_b_d;
    logic              rly_a5_q;
    logic              rly_a5_d;
    logic              rly_a6_q;
    logic              rly_a6_d;

    always_comb begin
        flags_d               = '0;
        flags_d[FLG_AUTO]     = (op_mode == OP_AUTO);
        flags_d[FLG_MANUAL]   = (op_mode == OP_MANUAL);
        flags_d[FLG_LAMP]     = ctrl_q[CTRL_LAMP_BIT];
        flags_d[FLG_ACK]      = ack.pulse;
        flags_d[FLG_B_CLOSED] = closed_b;
        flags_d[FLG_A_CLOSED] = closed_a;
        flags_d[FLG_SETTLE]   = single_mode && (settle_d != '0);
        flags_d[FLG_B_SYNC]   = seq_b_d.sync;
        flags_d[FLG_B_OPEN]   = seq_b_d.opening;
        flags_d[FLG_B_CLOSE]  = seq_b_d.closing;
        flags_d[FLG_A_SYNC]   = seq_a_d.sync;
        flags_d[FLG_A_OPEN]   = seq_a_d.opening;
        flags_d[FLG_A_CLOSE]  = seq_a_d.closing;
        flags_d[FLG_B_UNLOAD] = seq_b_d.unload;
        flags_d[FLG_A_UNLOAD] = seq_a_d.unload;
        flags_d[FLG_ALT1]     = ctrl_q[CTRL_ALT1_BIT];
        flags_d[FLG_ALT2]     = ctrl_q[CTRL_ALT2_BIT];
        flags_d[FLG_REMOTE +: REMOTE_W] = remote_q;
        // relay select is read live, so changing it mid-close moves the command
        rly_b_d  = seq_b_d.closing;
        rly_a5_d = seq_a_d.closing && !ctrl_q[CTRL_RSEL_BIT];
        rly_a6_d = seq_a_d.closing && ctrl_q[CTRL_RSEL_BIT];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags_q  <= '0;
            rly_b_q  <= 1'b0;
            rly_a5_q <= 1'b0;
            rly_a6_q <= 1'b0;
        end else begin
            flags_q  <= flags_d;
            rly_b_q  <= rly_b_d;
            rly_a5_q <= rly_a5_d;
            rly_a6_q <= rly_a6_d;
        end
    end

    assign status_flags   = flags_q;
    assign relay_close_b  = rly_b_q;
    assign relay_close_a5 = rly_a5_q;
    assign relay_close_a6 = rly_a6_q;

endmodule // breaker_status_flags
`default_nettype wire

// ### dv/breaker_status_flags_monitor.sv
// breaker_status_flags_monitor: port-level assertions for the status flag block
// assumes it is bound into breaker_status_flags with a matching ACK_CYCLES
`default_nettype none
module breaker_status_flags_monitor
    import breaker_flags_pkg::*;
#(
    parameter tick_t ACK_CYCLES = tick_t'(ACK_PULSE_CYC)
) (
    // clock and reset
    input wire logic              core_clk,
    input wire logic              rst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // breaker side
    input wire logic              reply_input_a,
    input wire logic              reply_input_b,
    input wire logic              ack_button,
    input wire logic              ack_ext,
    input wire logic              relay_close_b,
    input wire logic              relay_close_a5,
    input wire logic              relay_close_a6,
    // flags
    input wire logic [FLAG_W-1:0] status_flags
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    tick_t hi_cnt_q;
    // length of the current acknowledge pulse
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) hi_cnt_q <= '0;
        else hi_cnt_q <= status_flags[FLG_ACK] ? hi_cnt_q + 1'b1 : '0;
    end
    property p_b_closed;
        !$past(rst) |-> status_flags[FLG_B_CLOSED] == !$past(reply_input_b);
    endproperty
    a_b_closed: assert property (p_b_closed) else $error("b closed flag wrong");
    property p_a_closed;
        !$past(rst) |-> status_flags[FLG_A_CLOSED] == !$past(reply_input_a);
    endproperty
    a_a_closed: assert property (p_a_closed) else $error("a closed flag wrong");
    property p_b_close;
        status_flags[FLG_B_CLOSE] == relay_close_b;
    endproperty
    a_b_close: assert property (p_b_close) else $error("b closing differs");
    property p_a_close;
        !(relay_close_a5 && relay_close_a6)
            && status_flags[FLG_A_CLOSE] == (relay_close_a5 || relay_close_a6);
    endproperty
    a_a_close: assert property (p_a_close) else $error("a closing differs");
    property p_a_open;
        $fell(status_flags[FLG_A_OPEN]) |-> $past(reply_input_a);
    endproperty
    a_a_open: assert property (p_a_open) else $error("a opening ended early");
    property p_b_open;
        $fell(status_flags[FLG_B_OPEN]) |-> $past(reply_input_b);
    endproperty
    a_b_open: assert property (p_b_open) else $error("b opening ended early");
    property p_a_sync;
        $fell(status_flags[FLG_A_SYNC]) |-> !$past(reply_input_a);
    endproperty
    a_a_sync: assert property (p_a_sync) else $error("a sync ended early");
    property p_ack_rise;
        ack_ext |-> ##2 status_flags[FLG_ACK];
    endproperty
    a_ack_rise: assert property (p_ack_rise) else $error("ack flag late");
    property p_ack_len;
        $fell(status_flags[FLG_ACK]) |-> hi_cnt_q >= ACK_CYCLES;
    endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack pulse short");
    property p_remote;
        reg_wr && reg_addr == REMOTE_ADDR
            |-> ##2 status_flags[FLG_REMOTE +: REMOTE_W] == $past(reg_wdata[7:0], 2);
    endproperty
    a_remote: assert property (p_remote) else $error("remote flags wrong");
endmodule // breaker_status_flags_monitor
bind breaker_status_flags breaker_status_flags_monitor #(.ACK_CYCLES(ACK_CYCLES)) u_mon (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reply_input_a(reply_input_a), .reply_input_b(reply_input_b),
    .ack_button(ack_button), .ack_ext(ack_ext), .relay_close_b(relay_close_b),
    .relay_close_a5(relay_close_a5), .relay_close_a6(relay_close_a6),
    .status_flags(status_flags));
`default_nettype wire

// ### dv/breaker_model.sv
// breaker_model: one breaker with its reply contact, high while open
// assumes the close relay is a level and open requests come from the bench
`default_nettype none
module breaker_model (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       close_cmd,
    input  wire logic       open_req,
    input  wire logic [3:0] delay,
    output var  logic       reply_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q;
    // contact moves only after the mechanism delay has run out
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reply_q <= 1'b1;
            cnt_q <= '0;
        end else if ((close_cmd && reply_q) || (open_req && !reply_q)) begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q >= delay) begin
                reply_q <= ~reply_q;
                cnt_q <= '0;
            end
        end else cnt_q <= '0;
    end
endmodule // breaker_model
`default_nettype wire

// ### dv/breaker_status_flags_test.sv
// breaker_status_flags_test: self-checking bench for the status flag block
// assumes one breaker model per reply input and shortened ack and settle counts
`default_nettype none
module breaker_status_flags_test
    import breaker_flags_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int ACK = 8;
    localparam int SETTLE = 16;
    localparam int HOLD = 20;
    logic        core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, ack_button = 0, ack_ext = 0;
    logic [7:0]  reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, rd_val;
    logic        reply_a, reply_b, rc_b, rc_a5, rc_a6, open_a = 0, open_b = 0;
    logic [3:0]  dly = 1;
    logic [24:0] flags;
    int          err_count = 0, compares = 0, cyc = 0, n, hold = 0, held = 0;
    always #50 core_clk = ~core_clk;
    // consumer-side delay timer that stretches the short acknowledge flag
    always @(posedge core_clk) begin
        if (flags[FLG_ACK] === 1'b1) hold <= HOLD;
        else if (hold > 0) hold <= hold - 1;
        if (hold > 0) held++;
    end
    breaker_status_flags #(.ACK_CYCLES(tick_t'(ACK)), .SETTLE_CYCLES(tick_t'(SETTLE))) DUT (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reply_input_a(reply_a),
        .reply_input_b(reply_b), .ack_button(ack_button), .ack_ext(ack_ext),
        .relay_close_b(rc_b), .relay_close_a5(rc_a5), .relay_close_a6(rc_a6),
        .status_flags(flags));
    breaker_model brk_a (.core_clk(core_clk), .rst(rst), .close_cmd(rc_a5 | rc_a6),
        .open_req(open_a), .delay(dly), .reply_q(reply_a));
    breaker_model brk_b (.core_clk(core_clk), .rst(rst), .close_cmd(rc_b),
        .open_req(open_b), .delay(dly), .reply_q(reply_b));
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(negedge core_clk);
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        rd_val = reg_rdata;
    endtask
    // counts high cycles of one flag over a fixed window
    task automatic count_high(int i, int win);
        n = 0;
        repeat (win) begin
            @(negedge core_clk);
            if (flags[i] === 1'b1) n++;
        end
    endtask
    task automatic wait_bit(int i, logic v);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (flags[i] !== v && n < 40);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        logic [7:0] d;
        int fs[2], fo[2], fc[2], fu[2], fk[2], cb;
        fs = '{FLG_A_SYNC, FLG_B_SYNC};
        fo = '{FLG_A_OPEN, FLG_B_OPEN};
        fc = '{FLG_A_CLOSE, FLG_B_CLOSE};
        fu = '{FLG_A_UNLOAD, FLG_B_UNLOAD};
        fk = '{FLG_A_CLOSED, FLG_B_CLOSED};
        void'($urandom(31310));
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk("flags_reset", 0, {7'h0, flags});
        for (int m = 0; m < 4; m++) begin
            d = 8'($urandom) & 8'h1C | 8'(m);
            wr(CTRL_ADDR, 32'(d));
            rd(STATUS_ADDR);
            chk("mode", {d[4:2], m == 2, m == 1}, {flags[16:15], flags[2:0]});
            chk("mode_rd", {d[4:2], m == 2, m == 1}, {rd_val[16:15], rd_val[2:0]});
        end
        $display("test modes done");
        repeat (4) begin
            d = 8'($urandom);
            wr(REMOTE_ADDR, 32'(d));
            @(negedge core_clk);
            chk("remote", d, flags[24:17]);
            wr(STATUS_ADDR, 32'hFFFF_FFFF);
            rd(STATUS_ADDR);
            chk("remote_rd", d, rd_val[24:17]);
        end
        rd(CMD_ADDR);
        chk("cmd_rd", 0, rd_val);
        rd(8'h10);
        chk("unmapped_rd", 0, rd_val);
        $display("test remote done");
        for (int s = 0; s < 2; s++) begin
            cb = s ? CMD_SYNC_B : CMD_SYNC_A;
            d = 8'($urandom_range(1));
            dly <= 4'($urandom_range(6));
            wr(CTRL_ADDR, 32'(d) << 5 | 32'h0000_0001);
            wr(CMD_ADDR, 32'h0000_0005 << cb);
            chk("sync_close", 3, {flags[fs[s]], flags[fc[s]]});
            chk("relays", s ? 3'b100 : {1'b0, d[0], !d[0]}, {rc_b, rc_a6, rc_a5});
            wait_bit(fk[s], 1'b1);
            chk("closed", 3'b100, {flags[fk[s]], flags[fs[s]], flags[fc[s]]});
            wr(CMD_ADDR, 32'h0000_0008 << cb);
            chk("unload", 1, flags[fu[s]]);
            wr(CMD_ADDR, 32'h0000_0002 << cb);
            if (s) open_b <= 1'b1;
            else open_a <= 1'b1;
            chk("opening", 2, {flags[fo[s]], flags[fu[s]]});
            wait_bit(fk[s], 1'b0);
            chk("opened", 0, {flags[fk[s]], flags[fo[s]]});
            open_a <= 1'b0;
            open_b <= 1'b0;
        end
        $display("test breakers done");
        held = 0;
        @(posedge core_clk);
        ack_ext <= 1'b1;
        @(posedge core_clk);
        ack_ext <= 1'b0;
        count_high(FLG_ACK, 30);
        chk("ack_ext", ACK, n);
        chk("ack_held", ACK + HOLD - 1, held);
        wr(CMD_ADDR, 32'h0000_0001);
        count_high(FLG_ACK, 30);
        chk("ack_cmd", ACK, n);
        @(posedge core_clk);
        ack_button <= 1'b1;
        count_high(FLG_ACK, 30);
        chk("ack_button", ACK, n);
        @(posedge core_clk);
        ack_button <= 1'b0;
        $display("test acknowledge done");
        for (int a = 0; a < 3; a++) begin
            wr(CTRL_ADDR, 32'(a) << 6 | 32'h0000_0001);
            wr(CMD_ADDR, 32'h0000_0200);
            count_high(FLG_SETTLE, 40);
            chk("settle", a < 2, n >= SETTLE - 2 && n <= SETTLE);
        end
        $display("test settling done");
        summarize();
    end
endmodule // breaker_status_flags_test
`default_nettype wire
